/* File: shared/pfdsc_defines.vh */
// Register map, field codes and state codes for the power-fail deceleration controller.
`ifndef PFDSC_DEFINES_VH
`define PFDSC_DEFINES_VH
`define PFDSC_ADDR_W 8
`define PFDSC_OFF_SELECT 8'h00
`define PFDSC_OFF_COAST_TIME 8'h04
`define PFDSC_OFF_TERM_ASSIGN0 8'h08
`define PFDSC_OFF_TERM_ASSIGN1 8'h0c
`define PFDSC_OFF_TERM_ASSIGN2 8'h10
`define PFDSC_OFF_USER_GROUP 8'h14
`define PFDSC_OFF_STATUS 8'h18
`define PFDSC_OFF_IRQ_STATUS 8'h1c
`define PFDSC_OFF_IRQ_MASK 8'h20
`define PFDSC_OFF_FREQ_STEP 8'h24
`define PFDSC_SELECT_RESET 2'h0
`define PFDSC_SEL_COAST 2'h0
`define PFDSC_SEL_STOP 2'h1
`define PFDSC_SEL_CONTINUE 2'h2
`define PFDSC_COAST_DISABLED 16'h270f
`define PFDSC_COAST_RESET 16'h270f
`define PFDSC_TERM_POS 8'h2e
`define PFDSC_TERM_NEG 8'h92
`define PFDSC_TERM_RESET 8'h00
`define PFDSC_STEP_RESET 16'h0001
`define PFDSC_IRQ_W 4
`define PFDSC_IRQ_COAST 0
`define PFDSC_IRQ_DECEL 1
`define PFDSC_IRQ_STOPPED 2
`define PFDSC_IRQ_REACCEL 3
`define PFDSC_RESP_OKAY 2'h0
`define PFDSC_RESP_SLVERR 2'h2
`define PFDSC_ST_NORMAL 5'h01
`define PFDSC_ST_COAST 5'h02
`define PFDSC_ST_DECEL 5'h04
`define PFDSC_ST_HELD 5'h08
`define PFDSC_ST_REACCEL 5'h10
`endif

/* File: hdl/pfdsc_term_map.v */
// Output terminal mapper for the power-fail deceleration status.
`timescale 1ns/1ps
`default_nettype none
`include "pfdsc_defines.vh"
module pfdsc_term_map (
   input wire clk,
   input wire rst_n,
   input wire status_in,
   input wire [23:0] assign_codes,
   output wire [2:0] term_out
);
   reg [2:0] term_reg;
   genvar i;
   // Each terminal drives the status when its code is 46 (positive) or 146 (inverted), else stays low.
   generate
      for (i = 0; i < 3; i = i + 1) begin : g_term
         always @(posedge clk) begin
            if (!rst_n) begin
               term_reg[i] <= 1'b0;
            end else if (assign_codes[i*8 +: 8] == `PFDSC_TERM_POS) begin
               term_reg[i] <= status_in;
            end else if (assign_codes[i*8 +: 8] == `PFDSC_TERM_NEG) begin
               term_reg[i] <= ~status_in;
            end else begin
               term_reg[i] <= 1'b0;
            end
         end
      end
   endgenerate
   assign term_out = term_reg;
endmodule // pfdsc_term_map
`default_nettype wire

/* File: hdl/pfdsc_ctrl.v */
// Power-fail deceleration-to-stop controller with AXI4-Lite registers.
//
// The AXI4-Lite interface to the registers and the register addresses were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
`include "pfdsc_defines.vh"
// Operation
// - Selection 0 shuts output off, motor coasts.
// - Selection 1 or 2 decelerates on failure.
// - Lower frequency under bus regulation to zero.
// - Selection 1 finishes deceleration, stays stopped.
// - Held start ignored; off then on restarts.
// - Coast time not 9999 disables stop response.
// - Selection 2 reaccelerates when supply returns.
// - Start dropping in selection 2 uses normal decel.
// - Status high decelerating and stopped afterwards.
// - Terminal shows status for codes 46, 146.
// - No response when already stopped or tripped.
// - Selection writable only when user group is 0.
module pfdsc_ctrl (
   input wire clk,
   input wire rst_n,
   input wire [7:0] s_axi_awaddr,
   input wire s_axi_awvalid,
   output wire s_axi_awready,
   input wire [31:0] s_axi_wdata,
   input wire [3:0] s_axi_wstrb,
   input wire s_axi_wvalid,
   output wire s_axi_wready,
   output wire [1:0] s_axi_bresp,
   output wire s_axi_bvalid,
   input wire s_axi_bready,
   input wire [7:0] s_axi_araddr,
   input wire s_axi_arvalid,
   output wire s_axi_arready,
   output wire [31:0] s_axi_rdata,
   output wire [1:0] s_axi_rresp,
   output wire s_axi_rvalid,
   input wire s_axi_rready,
   input wire power_fail_detect,
   input wire undervoltage_detect,
   input wire forward_start_command,
   input wire reverse_start_command,
   input wire drive_running,
   input wire drive_tripped,
   input wire bus_voltage_low,
   input wire [15:0] set_frequency,
   output wire [15:0] pf_freq_target,
   output wire pf_override,
   output wire output_shutoff,
   output wire normal_decel_request,
   output wire start_enable,
   output wire auto_restart_enable,
   output wire power_fail_decel_status,
   output wire [2:0] terminal_out,
   output wire irq
);
   reg [1:0] power_fail_response_select_reg;
   reg [15:0] restart_coast_time_setting_reg;
   reg [23:0] term_assign_reg;
   reg [7:0] user_group_read_select_reg;
   reg [15:0] freq_step_reg;
   reg [3:0] irq_status_reg;
   reg [3:0] irq_mask_reg;
   reg [4:0] state_reg;
   reg [4:0] state_next;
   reg [15:0] freq_reg;
   reg [15:0] freq_next;
   reg [1:0] mode_reg;
   reg rearm_block_reg;
   reg [3:0] ev;
   reg aw_hold_reg;
   reg [7:0] aw_addr_reg;
   reg w_hold_reg;
   reg [31:0] w_data_reg;
   reg [3:0] w_strb_reg;
   reg bvalid_reg;
   reg [1:0] bresp_reg;
   reg rvalid_reg;
   reg [31:0] rdata_reg;
   reg [1:0] rresp_reg;
   wire fail;
   wire start_cmd;
   wire stop_enabled;
   wire do_write;
   wire [31:0] wmask;
   wire addr_ok;

   // Either detection is the same trigger; restoration needs both clear.
   assign fail = power_fail_detect | undervoltage_detect;
   assign start_cmd = forward_start_command | reverse_start_command;
   // Automatic restart takes precedence when its coasting time is configured.
   assign stop_enabled = (restart_coast_time_setting_reg == `PFDSC_COAST_DISABLED);
   assign auto_restart_enable = ~stop_enabled;

   // Supervisory state machine; a failure in the normal state is only acted on while the drive runs healthy.
   always @* begin
      state_next = state_reg;
      freq_next = freq_reg;
      ev = 4'h0;
      case (state_reg)
         `PFDSC_ST_NORMAL: begin
            freq_next = set_frequency;
            if (fail && drive_running && !drive_tripped && stop_enabled) begin
               if (power_fail_response_select_reg == `PFDSC_SEL_COAST) begin
                  state_next = `PFDSC_ST_COAST;
                  ev[`PFDSC_IRQ_COAST] = 1'b1;
               end else begin
                  state_next = `PFDSC_ST_DECEL;
                  ev[`PFDSC_IRQ_DECEL] = 1'b1;
               end
            end
         end
         `PFDSC_ST_COAST: begin
            if (!fail) begin
               state_next = `PFDSC_ST_NORMAL;
            end
         end
         `PFDSC_ST_DECEL: begin
            if (!fail && mode_reg == `PFDSC_SEL_CONTINUE && start_cmd) begin
               state_next = `PFDSC_ST_REACCEL;
               ev[`PFDSC_IRQ_REACCEL] = 1'b1;
            end else if (drive_tripped) begin
               state_next = `PFDSC_ST_NORMAL;
            end else if (mode_reg == `PFDSC_SEL_CONTINUE && !start_cmd) begin
               state_next = `PFDSC_ST_NORMAL;
            end else if (bus_voltage_low) begin
               // The bus pause also holds back the last drop to zero, so the bus never sags on it.
               freq_next = freq_reg;
            end else if (freq_reg <= freq_step_reg) begin
               freq_next = 16'h0000;
               state_next = `PFDSC_ST_HELD;
               ev[`PFDSC_IRQ_STOPPED] = 1'b1;
            end else begin
               freq_next = freq_reg - freq_step_reg;
            end
         end
         `PFDSC_ST_HELD: begin
            if (!fail && !start_cmd) begin
               state_next = `PFDSC_ST_NORMAL;
            end
         end
         `PFDSC_ST_REACCEL: begin
            if (fail) begin
               state_next = `PFDSC_ST_DECEL;
               ev[`PFDSC_IRQ_DECEL] = 1'b1;
            end else if (!start_cmd || drive_tripped) begin
               state_next = `PFDSC_ST_NORMAL;
            end else if (set_frequency - freq_reg <= freq_step_reg || freq_reg >= set_frequency) begin
               freq_next = set_frequency;
               state_next = `PFDSC_ST_NORMAL;
            end else begin
               freq_next = freq_reg + freq_step_reg;
            end
         end
         default: begin
            state_next = `PFDSC_ST_NORMAL;
         end
      endcase
   end

   // The response mode is latched at the failure so a mid-event write cannot change it.
   always @(posedge clk) begin
      if (!rst_n) begin
         state_reg <= `PFDSC_ST_NORMAL;
         freq_reg <= 16'h0000;
         mode_reg <= `PFDSC_SEL_COAST;
         rearm_block_reg <= 1'b0;
      end else begin
         state_reg <= state_next;
         freq_reg <= freq_next;
         if (state_reg == `PFDSC_ST_NORMAL) begin
            mode_reg <= power_fail_response_select_reg;
         end
         // A start held through the stopped or coasting state stays blocked until it is released once.
         if (state_reg == `PFDSC_ST_HELD || state_reg == `PFDSC_ST_COAST) begin
            rearm_block_reg <= 1'b1;
         end else if (!start_cmd) begin
            rearm_block_reg <= 1'b0;
         end
      end
   end

   assign pf_freq_target = freq_reg;
   assign pf_override = (state_reg == `PFDSC_ST_DECEL) || (state_reg == `PFDSC_ST_REACCEL) ||
                        (state_reg == `PFDSC_ST_HELD);
   assign output_shutoff = (state_reg == `PFDSC_ST_COAST) || (state_reg == `PFDSC_ST_HELD);
   assign normal_decel_request = (state_reg == `PFDSC_ST_DECEL) && (mode_reg == `PFDSC_SEL_CONTINUE) &&
                                 !start_cmd;
   assign start_enable = start_cmd && !rearm_block_reg && (state_reg == `PFDSC_ST_NORMAL) && !fail;
   assign power_fail_decel_status = (state_reg == `PFDSC_ST_DECEL) || (state_reg == `PFDSC_ST_HELD);

   pfdsc_term_map u_term (
      .clk(clk),
      .rst_n(rst_n),
      .status_in(power_fail_decel_status),
      .assign_codes(term_assign_reg),
      .term_out(terminal_out)
   );

   // Write channel capture: address and data are taken independently, in either order.
   assign s_axi_awready = !aw_hold_reg && !bvalid_reg;
   assign s_axi_wready = !w_hold_reg && !bvalid_reg;
   assign do_write = aw_hold_reg && w_hold_reg && !bvalid_reg;
   assign wmask = {{8{w_strb_reg[3]}}, {8{w_strb_reg[2]}}, {8{w_strb_reg[1]}}, {8{w_strb_reg[0]}}};
   assign addr_ok = (aw_addr_reg[1:0] == 2'h0) && (aw_addr_reg <= `PFDSC_OFF_FREQ_STEP);

   // Register writes; hardware events win over a simultaneous write-one clear.
   always @(posedge clk) begin
      if (!rst_n) begin
         aw_hold_reg <= 1'b0;
         aw_addr_reg <= 8'h00;
         w_hold_reg <= 1'b0;
         w_data_reg <= 32'h00000000;
         w_strb_reg <= 4'h0;
         bvalid_reg <= 1'b0;
         bresp_reg <= `PFDSC_RESP_OKAY;
         power_fail_response_select_reg <= `PFDSC_SELECT_RESET;
         restart_coast_time_setting_reg <= `PFDSC_COAST_RESET;
         term_assign_reg <= {3{`PFDSC_TERM_RESET}};
         user_group_read_select_reg <= 8'h00;
         freq_step_reg <= `PFDSC_STEP_RESET;
         irq_status_reg <= 4'h0;
         irq_mask_reg <= 4'h0;
      end else begin
         if (s_axi_awvalid && s_axi_awready) begin
            aw_hold_reg <= 1'b1;
            aw_addr_reg <= s_axi_awaddr;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_hold_reg <= 1'b1;
            w_data_reg <= s_axi_wdata;
            w_strb_reg <= s_axi_wstrb;
         end
         if (bvalid_reg && s_axi_bready) begin
            bvalid_reg <= 1'b0;
         end
         irq_status_reg <= irq_status_reg | ev;
         if (do_write) begin
            aw_hold_reg <= 1'b0;
            w_hold_reg <= 1'b0;
            bvalid_reg <= 1'b1;
            bresp_reg <= addr_ok ? `PFDSC_RESP_OKAY : `PFDSC_RESP_SLVERR;
            case (aw_addr_reg)
               `PFDSC_OFF_SELECT: begin
                  // Code 3 in bits [1:0] is outside the setting range and is refused; higher bits are ignored.
                  if (user_group_read_select_reg == 8'h00 && w_strb_reg[0] && w_data_reg[1:0] != 2'h3) begin
                     power_fail_response_select_reg <= w_data_reg[1:0];
                  end
               end
               `PFDSC_OFF_COAST_TIME: begin
                  restart_coast_time_setting_reg <= (restart_coast_time_setting_reg & ~wmask[15:0]) |
                                                    (w_data_reg[15:0] & wmask[15:0]);
               end
               `PFDSC_OFF_TERM_ASSIGN0: begin
                  if (w_strb_reg[0]) term_assign_reg[7:0] <= w_data_reg[7:0];
               end
               `PFDSC_OFF_TERM_ASSIGN1: begin
                  if (w_strb_reg[0]) term_assign_reg[15:8] <= w_data_reg[7:0];
               end
               `PFDSC_OFF_TERM_ASSIGN2: begin
                  if (w_strb_reg[0]) term_assign_reg[23:16] <= w_data_reg[7:0];
               end
               `PFDSC_OFF_USER_GROUP: begin
                  if (w_strb_reg[0]) user_group_read_select_reg <= w_data_reg[7:0];
               end
               `PFDSC_OFF_IRQ_STATUS: begin
                  if (w_strb_reg[0]) irq_status_reg <= (irq_status_reg & ~w_data_reg[3:0]) | ev;
               end
               `PFDSC_OFF_IRQ_MASK: begin
                  if (w_strb_reg[0]) irq_mask_reg <= w_data_reg[3:0];
               end
               `PFDSC_OFF_FREQ_STEP: begin
                  freq_step_reg <= (freq_step_reg & ~wmask[15:0]) | (w_data_reg[15:0] & wmask[15:0]);
               end
               default: begin
                  bresp_reg <= addr_ok ? `PFDSC_RESP_OKAY : `PFDSC_RESP_SLVERR;
               end
            endcase
         end
      end
   end

   assign s_axi_bvalid = bvalid_reg;
   assign s_axi_bresp = bresp_reg;
   assign s_axi_arready = !rvalid_reg;

   // Read path answers one cycle after the address is taken; unmapped reads give zero and an error.
   always @(posedge clk) begin
      if (!rst_n) begin
         rvalid_reg <= 1'b0;
         rdata_reg <= 32'h00000000;
         rresp_reg <= `PFDSC_RESP_OKAY;
      end else if (s_axi_arvalid && s_axi_arready) begin
         rvalid_reg <= 1'b1;
         rresp_reg <= `PFDSC_RESP_OKAY;
         case (s_axi_araddr)
            `PFDSC_OFF_SELECT: rdata_reg <= {30'h0, power_fail_response_select_reg};
            `PFDSC_OFF_COAST_TIME: rdata_reg <= {16'h0, restart_coast_time_setting_reg};
            `PFDSC_OFF_TERM_ASSIGN0: rdata_reg <= {24'h0, term_assign_reg[7:0]};
            `PFDSC_OFF_TERM_ASSIGN1: rdata_reg <= {24'h0, term_assign_reg[15:8]};
            `PFDSC_OFF_TERM_ASSIGN2: rdata_reg <= {24'h0, term_assign_reg[23:16]};
            `PFDSC_OFF_USER_GROUP: rdata_reg <= {24'h0, user_group_read_select_reg};
            `PFDSC_OFF_STATUS: rdata_reg <= {9'h0, freq_reg, 1'b0, rearm_block_reg, state_reg};
            `PFDSC_OFF_IRQ_STATUS: rdata_reg <= {28'h0, irq_status_reg};
            `PFDSC_OFF_IRQ_MASK: rdata_reg <= {28'h0, irq_mask_reg};
            `PFDSC_OFF_FREQ_STEP: rdata_reg <= {16'h0, freq_step_reg};
            default: begin
               rdata_reg <= 32'h00000000;
               rresp_reg <= `PFDSC_RESP_SLVERR;
            end
         endcase
      end else if (rvalid_reg && s_axi_rready) begin
         rvalid_reg <= 1'b0;
      end
   end

   assign s_axi_rvalid = rvalid_reg;
   assign s_axi_rdata = rdata_reg;
   assign s_axi_rresp = rresp_reg;
   // Level interrupt while any unmasked sticky event is pending.
   assign irq = |(irq_status_reg & irq_mask_reg);
endmodule // pfdsc_ctrl
`default_nettype wire

/* File: tb/pfdsc_ctrl_assertions.sv */
// Concurrent checks on the ports of the power-fail deceleration controller.
`timescale 1ns/1ps
`default_nettype none
module pfdsc_ctrl_assertions (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic power_fail_detect,
   input wire logic undervoltage_detect,
   input wire logic forward_start_command,
   input wire logic reverse_start_command,
   input wire logic drive_running,
   input wire logic drive_tripped,
   input wire logic bus_voltage_low,
   input wire logic [15:0] pf_freq_target,
   input wire logic pf_override,
   input wire logic output_shutoff,
   input wire logic normal_decel_request,
   input wire logic start_enable,
   input wire logic auto_restart_enable,
   input wire logic power_fail_decel_status
);
   // Either detector counts as a failure; either start line counts as a start.
   wire fail = power_fail_detect | undervoltage_detect;
   wire st = forward_start_command | reverse_start_command;
   wire dec = power_fail_decel_status & ~output_shutoff;
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);
   chk_status_override: assert property (power_fail_decel_status |-> pf_override)
      else $error("decel status without override");
   chk_auto_restart: assert property (auto_restart_enable && !pf_override && !output_shutoff |=> !pf_override && !output_shutoff)
      else $error("stop response taken while auto restart selected");
   chk_idle_ignore: assert property ((!drive_running || drive_tripped) && !pf_override && !output_shutoff |=> !pf_override && !output_shutoff)
      else $error("stop response taken while stopped or tripped");
   chk_decel_down: assert property (dec && fail && st && !drive_tripped |=> pf_freq_target <= $past(pf_freq_target))
      else $error("frequency rose during decel");
   chk_bus_pause: assert property (dec && fail && st && !drive_tripped && bus_voltage_low |=> $stable(pf_freq_target))
      else $error("frequency moved while bus low");
   chk_stop_zero: assert property (power_fail_decel_status && output_shutoff |-> pf_freq_target == 16'h0000)
      else $error("stopped with nonzero frequency");
   chk_held_stays: assert property (power_fail_decel_status && output_shutoff && st |=> power_fail_decel_status && output_shutoff)
      else $error("left stop with start held");
   chk_rearm_block: assert property ($fell(output_shutoff) && !pf_override && st |-> !start_enable)
      else $error("held start accepted after stop");
   chk_normal_decel: assert property (normal_decel_request |-> !st ##1 !pf_override)
      else $error("normal decel request misplaced");
endmodule // pfdsc_ctrl_assertions
`default_nettype wire

/* File: tb/pfdsc_ctrl_tb_top.sv */
// Self-checking testbench for the power-fail deceleration controller.
`timescale 1ns/1ps
`default_nettype none
`include "pfdsc_defines.vh"
module pfdsc_ctrl_tb_top;
   logic clk = 1'b0, rst_n = 1'b0, s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
   logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, power_fail_detect = 1'b0, undervoltage_detect = 1'b0;
   logic forward_start_command = 1'b0, reverse_start_command = 1'b0, drive_running = 1'b0;
   logic drive_tripped = 1'b0, bus_voltage_low = 1'b0;
   logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
   logic [31:0] s_axi_wdata = 32'h0, rd;
   logic [3:0] s_axi_wstrb = 4'hf;
   logic [15:0] set_frequency = 16'h0000;
   logic [1:0] rs, bs;
   wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, pf_override, output_shutoff;
   wire normal_decel_request, start_enable, auto_restart_enable, power_fail_decel_status, irq;
   wire [1:0] s_axi_bresp, s_axi_rresp;
   wire [31:0] s_axi_rdata;
   wire [15:0] pf_freq_target;
   wire [2:0] terminal_out;
   int n_errors = 0, tests_run = 0, cycles = 0;
   pfdsc_ctrl pfdsc_ctrl_i (.*);
   // Clock of 4 ns period.
   initial begin
      forever #2 clk = ~clk;
   end
   // Hang guard; the whole run needs well under a thousand cycles.
   always @(posedge clk) begin
      cycles <= cycles + 1;
      if (cycles == 4000) begin
         n_errors++;
         stop_test();
      end
   end
   task automatic stop_test;
      $display("comparisons %0d mismatches %0d", tests_run, n_errors);
      if (n_errors == 0 && tests_run > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask
   task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      tests_run++;
      if (seen !== exp) begin
         n_errors++;
         $display("mismatch %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic step(input int n);
      repeat (n) @(posedge clk);
   endtask
   // Address and data go out together; each drops once taken, bready stays up until the response.
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      do begin
         @(posedge clk);
         if (s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wready) s_axi_wvalid <= 1'b0;
      end while (!s_axi_bvalid);
      bs = s_axi_bresp;
      s_axi_bready <= 1'b0;
   endtask
   task automatic rdreg(input logic [7:0] a);
      @(posedge clk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do begin
         @(posedge clk);
         if (s_axi_arready) s_axi_arvalid <= 1'b0;
      end while (!s_axi_rvalid);
      rd = s_axi_rdata;
      rs = s_axi_rresp;
      s_axi_rready <= 1'b0;
   endtask
   task automatic t_regs;
      rdreg(`PFDSC_OFF_COAST_TIME);
      check("coast reset", rd, 32'h270f);
      rdreg(8'h40);
      check("unmapped resp", rs, `PFDSC_RESP_SLVERR);
      wr(8'h40, 32'h0);
      check("unmapped wresp", bs, `PFDSC_RESP_SLVERR);
      wr(`PFDSC_OFF_STATUS, 32'h0);
      check("status wresp", bs, `PFDSC_RESP_OKAY);
      wr(`PFDSC_OFF_USER_GROUP, 32'h1);
      wr(`PFDSC_OFF_SELECT, 32'h2);
      rdreg(`PFDSC_OFF_SELECT);
      check("select locked", rd, 32'h0);
      wr(`PFDSC_OFF_USER_GROUP, 32'h0);
      $display("regs test done");
   endtask
   // Selection 0: ignored when stopped or tripped, then coast with shutoff.
   task automatic t_coast;
      @(posedge clk);
      forward_start_command <= 1'b1;
      undervoltage_detect <= 1'b1;
      @(negedge clk);
      check("stopped ignore", output_shutoff | pf_override, 1'b0);
      @(posedge clk);
      drive_running <= 1'b1;
      drive_tripped <= 1'b1;
      step(2);
      drive_tripped <= 1'b0;
      @(negedge clk);
      check("tripped ignore", output_shutoff | pf_override, 1'b0);
      @(negedge clk);
      check("coast shutoff", {output_shutoff, pf_override, power_fail_decel_status}, 3'b100);
      @(posedge clk);
      undervoltage_detect <= 1'b0;
      step(2);
      @(negedge clk);
      check("coast exit", {output_shutoff, start_enable}, 2'b00);
      @(posedge clk);
      forward_start_command <= 1'b0;
      step(1);
      forward_start_command <= 1'b1;
      @(negedge clk);
      check("restart", start_enable, 1'b1);
      wr(`PFDSC_OFF_IRQ_MASK, 32'h1);
      check("irq raised", irq, 1'b1);
      wr(`PFDSC_OFF_IRQ_STATUS, 32'h1);
      check("irq cleared", irq, 1'b0);
      $display("coast test done");
   endtask
   // Selection 1: decel with bus pause, supply back mid-decel, stays stopped until start re-armed.
   task automatic t_stop;
      wr(`PFDSC_OFF_SELECT, 32'h1);
      wr(`PFDSC_OFF_TERM_ASSIGN0, 32'h2e);
      wr(`PFDSC_OFF_TERM_ASSIGN1, 32'h92);
      @(posedge clk);
      set_frequency <= 16'h0010;
      step(3);
      power_fail_detect <= 1'b1;
      bus_voltage_low <= 1'b1;
      step(3);
      @(negedge clk);
      check("decel", {power_fail_decel_status, output_shutoff}, 2'b10);
      check("bus pause", pf_freq_target, 16'h0010);
      @(posedge clk);
      bus_voltage_low <= 1'b0;
      power_fail_detect <= 1'b0;
      for (int i = 0; i < 40 && !output_shutoff; i++) @(negedge clk);
      check("stop zero", pf_freq_target, 16'h0000);
      step(2);
      @(negedge clk);
      check("held", {power_fail_decel_status, output_shutoff, start_enable, irq}, 4'b1100);
      check("term map", terminal_out, 3'b001);
      @(posedge clk);
      forward_start_command <= 1'b0;
      step(2);
      forward_start_command <= 1'b1;
      @(negedge clk);
      check("rearmed", {power_fail_decel_status, start_enable}, 2'b01);
      check("term inverted", terminal_out, 3'b010);
      rdreg(`PFDSC_OFF_IRQ_STATUS);
      check("irq events", rd, 32'h6);
      wr(`PFDSC_OFF_IRQ_STATUS, 32'hf);
      $display("stop test done");
   endtask
   // Selection 2: supply back gives re-acceleration; start drop gives normal decel.
   task automatic t_cont;
      wr(`PFDSC_OFF_SELECT, 32'h2);
      @(posedge clk);
      forward_start_command <= 1'b0;
      reverse_start_command <= 1'b1;
      set_frequency <= 16'h0020;
      step(3);
      power_fail_detect <= 1'b1;
      step(6);
      power_fail_detect <= 1'b0;
      @(negedge clk);
      @(negedge clk);
      check("reaccel", {pf_override, power_fail_decel_status}, 2'b10);
      for (int i = 0; i < 80 && pf_override; i++) @(negedge clk);
      check("reaccel target", pf_freq_target, 16'h0020);
      @(posedge clk);
      power_fail_detect <= 1'b1;
      step(3);
      reverse_start_command <= 1'b0;
      drive_running <= 1'b0;
      @(negedge clk);
      check("normal decel", normal_decel_request, 1'b1);
      @(negedge clk);
      check("decel dropped", {pf_override, normal_decel_request}, 2'b00);
      @(posedge clk);
      power_fail_detect <= 1'b0;
      rdreg(`PFDSC_OFF_IRQ_STATUS);
      check("irq cont events", rd, 32'ha);
      $display("continue test done");
   endtask
   task automatic t_auto;
      wr(`PFDSC_OFF_COAST_TIME, 32'h5);
      @(posedge clk);
      drive_running <= 1'b1;
      forward_start_command <= 1'b1;
      power_fail_detect <= 1'b1;
      step(3);
      @(negedge clk);
      check("auto restart", {auto_restart_enable, pf_override, output_shutoff}, 3'b100);
      $display("auto test done");
   endtask
   initial begin
      step(4);
      rst_n <= 1'b1;
      t_regs();
      t_coast();
      t_stop();
      t_cont();
      t_auto();
      stop_test();
   end
endmodule // pfdsc_ctrl_tb_top
bind pfdsc_ctrl pfdsc_ctrl_assertions pfdsc_ctrl_assertions_i (.*);
`default_nettype wire
